// File: core/wec_map.vh
// register offsets, field positions, reset values and timing counts of the wake combiner
`ifndef WEC_MAP_VH
`define WEC_MAP_VH
// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define WEC_OFF_PMCTRL      12'h000
`define WEC_OFF_ISTAT       12'h004
`define WEC_OFF_IMASK       12'h008
`define WEC_OFF_PHYMASK     12'h00C
`define WEC_OFF_HMWAKE      12'h010
// ----------------------------------------------------------------------------
// power_mgmt_control fields
// ----------------------------------------------------------------------------
`define WEC_PM_P1_SEEN      0
`define WEC_PM_P2_SEEN      1
`define WEC_PM_LAN_SEEN     2
`define WEC_PM_P1_EN        3
`define WEC_PM_P2_EN        4
`define WEC_PM_LAN_EN       5
`define WEC_PM_OUT_EN       6
`define WEC_PM_TYPE         7
`define WEC_PM_PULSE        8
`define WEC_PM_POL          9
`define WEC_PM_P1_GPD       10
`define WEC_PM_P2_GPD       11
`define WEC_PM_P1_EDPD      12
`define WEC_PM_P2_EDPD      13
`define WEC_PM_P1_PWRDN     14
`define WEC_PM_P2_PWRDN     15
`define WEC_PM_RST          16'h0000
// ----------------------------------------------------------------------------
// interrupt_status fields
// ----------------------------------------------------------------------------
`define WEC_IS_PWR_EVENT    17
`define WEC_IS_P1_IRQ       26
`define WEC_IS_P2_IRQ       27
`define WEC_IS_RST          32'h0000_0000
// ----------------------------------------------------------------------------
// host mac wake control/status fields
// ----------------------------------------------------------------------------
`define WEC_HM_WU_EN        0
`define WEC_HM_MP_EN        1
`define WEC_HM_WU_RX        2
`define WEC_HM_MP_RX        3
`define WEC_HM_RST          4'h0
// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define WEC_CLK_HZ          20000000
`define WEC_PULSE_MS        50
`define WEC_PULSE_CYC       ((`WEC_CLK_HZ / 1000) * `WEC_PULSE_MS)
`endif

// File: core/wec_pulse_timer.v
// down counter that times the single wake output pulse
module wec_pulse_timer #(
    parameter CYCLES = 1000000,
    parameter WIDTH  = 20
) (
    input  wire pclk,
    input  wire presetn,
    input  wire start,
    output wire busy
);
    reg [WIDTH-1:0] count_q;

    // ------------------------------------------------------------------------
    // count
    // ------------------------------------------------------------------------
    // a start while running is ignored so one event gives one pulse
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= {WIDTH{1'b0}};
        end else if (start && (count_q == {WIDTH{1'b0}})) begin
            count_q <= CYCLES[WIDTH-1:0];
        end else if (count_q != {WIDTH{1'b0}}) begin
            count_q <= count_q - {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    assign busy = (count_q != {WIDTH{1'b0}});
endmodule // wec_pulse_timer

// File: core/wec_wake_event_combiner.v
// wake event combiner: latched wake status, power event irq and wake pin shaping
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`include "wec_map.vh"

module wec_wake_event_combiner #(
    parameter PULSE_CYCLES = `WEC_PULSE_CYC
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        port1_energy_on_event,
    input  wire        port2_energy_on_event,
    input  wire        port1_other_phy_event,
    input  wire        port2_other_phy_event,
    input  wire        wakeup_frame_detect,
    input  wire        magic_packet_detect,
    output wire        port1_powered_down,
    output wire        port2_powered_down,
    output wire        host_irq,
    output wire        host_irq_deassert_timer_start,
    output reg         wake_event_out_o,
    output reg         wake_event_out_oe,
    output wire        irq
);
    // ------------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------------
    reg  [5:0] sync1_q;
    reg  [5:0] sync2_q;
    reg  [5:0] sync3_q;
    wire [5:0] rise;

    // pins come from other domains; third stage only for edge detect
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= 6'h00;
            sync2_q <= 6'h00;
            sync3_q <= 6'h00;
        end else begin
            sync1_q <= {magic_packet_detect, wakeup_frame_detect,
                        port2_other_phy_event, port1_other_phy_event,
                        port2_energy_on_event, port1_energy_on_event};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    assign rise = sync2_q & ~sync3_q;

    // ------------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------------
    wire wr_en;
    wire rd_hit;
    wire sel_pm;
    wire sel_is;
    wire sel_im;
    wire sel_pk;
    wire sel_hm;

    assign sel_pm  = (paddr == `WEC_OFF_PMCTRL);
    assign sel_is  = (paddr == `WEC_OFF_ISTAT);
    assign sel_im  = (paddr == `WEC_OFF_IMASK);
    assign sel_pk  = (paddr == `WEC_OFF_PHYMASK);
    assign sel_hm  = (paddr == `WEC_OFF_HMWAKE);
    assign rd_hit  = sel_pm | sel_is | sel_im | sel_pk | sel_hm;
    // zero wait state slave; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~rd_hit;
    assign wr_en   = psel & penable & pwrite;

    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    reg  [15:0] pm_q;
    reg  [31:0] is_en_q;
    reg  [1:0]  phy_mask_q;
    reg  [3:0]  hm_q;
    reg  [1:0]  phy_src_q;
    wire [15:0] pm_w1c;
    wire [3:0]  hm_w1c;
    wire [1:0]  phy_w1c;
    wire        p1_set;
    wire        p2_set;
    wire        wu_set;
    wire        mp_set;
    wire        lan_seen;
    wire        p1_seen;
    wire        p2_seen;
    wire        power_event_irq_status;

    assign pm_w1c  = (wr_en && sel_pm) ? pwdata[15:0] : 16'h0000;
    assign hm_w1c  = (wr_en && sel_hm) ? pwdata[3:0] : 4'h0;
    assign phy_w1c = (wr_en && sel_is) ?
                     {pwdata[`WEC_IS_P2_IRQ], pwdata[`WEC_IS_P1_IRQ]} : 2'b00;

    assign wu_set = rise[4] & hm_q[`WEC_HM_WU_EN];
    assign mp_set = rise[5] & hm_q[`WEC_HM_MP_EN];

    // host mac wake control: enables plus sticky received flags
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hm_q <= `WEC_HM_RST;
        end else begin
            if (wr_en && sel_hm) begin
                hm_q[`WEC_HM_WU_EN] <= pwdata[`WEC_HM_WU_EN];
                hm_q[`WEC_HM_MP_EN] <= pwdata[`WEC_HM_MP_EN];
            end
            hm_q[`WEC_HM_WU_RX] <= wu_set |
                (hm_q[`WEC_HM_WU_RX] & ~hm_w1c[`WEC_HM_WU_RX]);
            hm_q[`WEC_HM_MP_RX] <= mp_set |
                (hm_q[`WEC_HM_MP_RX] & ~hm_w1c[`WEC_HM_MP_RX]);
        end
    end

    assign lan_seen = hm_q[`WEC_HM_WU_RX] | hm_q[`WEC_HM_MP_RX];

    // energy detection counts only while the port is powered down, by gpd or edpd
    assign p1_set = rise[0] & pm_q[`WEC_PM_P1_PWRDN];
    assign p2_set = rise[1] & pm_q[`WEC_PM_P2_PWRDN];

    // power management control register
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pm_q <= `WEC_PM_RST;
        end else begin
            if (wr_en && sel_pm) begin
                pm_q[`WEC_PM_POL:`WEC_PM_P1_EN] <= pwdata[`WEC_PM_POL:`WEC_PM_P1_EN];
                pm_q[`WEC_PM_P2_EDPD:`WEC_PM_P1_GPD] <=
                    pwdata[`WEC_PM_P2_EDPD:`WEC_PM_P1_GPD];
            end
            pm_q[`WEC_PM_P1_SEEN] <= p1_set |
                (pm_q[`WEC_PM_P1_SEEN] & ~pm_w1c[`WEC_PM_P1_SEEN]);
            pm_q[`WEC_PM_P2_SEEN] <= p2_set |
                (pm_q[`WEC_PM_P2_SEEN] & ~pm_w1c[`WEC_PM_P2_SEEN]);
            // lan status follows latched mac flags; a write one drops it for one cycle only
            pm_q[`WEC_PM_LAN_SEEN] <= lan_seen & ~(pm_w1c[`WEC_PM_LAN_SEEN] &
                ~wu_set & ~mp_set);
            // general power-down: software only; management stays reachable
            if (wr_en && sel_pm) begin
                pm_q[`WEC_PM_P1_PWRDN] <= pwdata[`WEC_PM_P1_GPD] | pwdata[`WEC_PM_P1_EDPD];
                pm_q[`WEC_PM_P2_PWRDN] <= pwdata[`WEC_PM_P2_GPD] | pwdata[`WEC_PM_P2_EDPD];
            end else begin
                // energy wakes an edpd port by itself, never a gpd port
                if (rise[0] && pm_q[`WEC_PM_P1_EDPD] && !pm_q[`WEC_PM_P1_GPD]) begin
                    pm_q[`WEC_PM_P1_PWRDN] <= 1'b0;
                end
                if (rise[1] && pm_q[`WEC_PM_P2_EDPD] && !pm_q[`WEC_PM_P2_GPD]) begin
                    pm_q[`WEC_PM_P2_PWRDN] <= 1'b0;
                end
            end
        end
    end

    assign p1_seen = pm_q[`WEC_PM_P1_SEEN];
    assign p2_seen = pm_q[`WEC_PM_P2_SEEN];
    assign port1_powered_down = pm_q[`WEC_PM_P1_PWRDN];
    assign port2_powered_down = pm_q[`WEC_PM_P2_PWRDN];

    assign power_event_irq_status =
        (p1_seen  & pm_q[`WEC_PM_P1_EN]) |
        (p2_seen  & pm_q[`WEC_PM_P2_EN]) |
        (pm_q[`WEC_PM_LAN_SEEN] & pm_q[`WEC_PM_LAN_EN]);

    // ------------------------------------------------------------------------
    // transceiver interrupts
    // ------------------------------------------------------------------------
    // mask bit 0 = port1 energy_on_mask_bit, bit 1 = port2
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phy_mask_q <= 2'b00;
            phy_src_q  <= 2'b00;
        end else begin
            if (wr_en && sel_pk) begin
                phy_mask_q <= pwdata[1:0];
            end
            // energy-on with its mask bit set, or other events, raise the port flag
            phy_src_q <= ((rise[1:0] & phy_mask_q) | rise[3:2]) |
                         (phy_src_q & ~phy_w1c);
        end
    end

    // interrupt enable for host irq, same layout as interrupt_status
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            is_en_q <= `WEC_IS_RST;
        end else if (wr_en && sel_im) begin
            is_en_q <= pwdata;
        end
    end

    wire [31:0] interrupt_status;
    wire        port1_transceiver_irq;
    wire        port2_transceiver_irq;

    assign port1_transceiver_irq = phy_src_q[0];
    assign port2_transceiver_irq = phy_src_q[1];

    assign interrupt_status = ({31'h0, port2_transceiver_irq} << `WEC_IS_P2_IRQ) |
                              ({31'h0, port1_transceiver_irq} << `WEC_IS_P1_IRQ) |
                              ({31'h0, power_event_irq_status} << `WEC_IS_PWR_EVENT);

    // power event reaches host irq too
    assign host_irq = |(interrupt_status & is_en_q);
    assign irq      = host_irq;

    // ------------------------------------------------------------------------
    // host irq de-assertion timer start
    // ------------------------------------------------------------------------
    reg        other_irq_q;
    wire       other_irq;

    assign other_irq = |(interrupt_status & is_en_q &
                         ~({31'h0, 1'b1} << `WEC_IS_PWR_EVENT));

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            other_irq_q <= 1'b0;
        end else begin
            other_irq_q <= other_irq;
        end
    end

    assign host_irq_deassert_timer_start = other_irq_q & ~other_irq;

    // ------------------------------------------------------------------------
    // wake output conditioning
    // ------------------------------------------------------------------------
    reg  gated_q;
    wire gated;
    wire pulse_busy;
    wire active;

    assign gated = power_event_irq_status & pm_q[`WEC_PM_OUT_EN];

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gated_q <= 1'b0;
        end else begin
            gated_q <= gated;
        end
    end

    wec_pulse_timer #(
        .CYCLES (PULSE_CYCLES),
        .WIDTH  (20)
    ) u_pulse (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (gated & ~gated_q & pm_q[`WEC_PM_PULSE]),
        .busy    (pulse_busy)
    );

    assign active = pm_q[`WEC_PM_PULSE] ? pulse_busy : gated_q;

    // buffer type and polarity; type 1 = push-pull, 0 = open-drain low
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_event_out_o  <= 1'b0;
            wake_event_out_oe <= 1'b0;
        end else if (pm_q[`WEC_PM_TYPE]) begin
            wake_event_out_o  <= pm_q[`WEC_PM_POL] ? active : ~active;
            wake_event_out_oe <= 1'b1;
        end else begin
            wake_event_out_o  <= 1'b0;
            wake_event_out_oe <= active;
        end
    end

    // ------------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------------
    always @* begin
        prdata = 32'h0000_0000;
        if (psel && !pwrite) begin
            if (sel_pm) begin
                prdata = {16'h0000, pm_q};
            end else if (sel_is) begin
                prdata = interrupt_status;
            end else if (sel_im) begin
                prdata = is_en_q;
            end else if (sel_pk) begin
                prdata = {30'h0, phy_mask_q};
            end else if (sel_hm) begin
                prdata = {28'h0, hm_q};
            end
        end
    end
endmodule // wec_wake_event_combiner

// File: verification/wec_combiner_asserts.sv
// concurrent checks on the wake event combiner ports
`include "wec_map.vh"
module wec_combiner_asserts #(
    parameter int PULSE_CYCLES = 1000000
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        port1_powered_down,
    input wire logic        port2_powered_down,
    input wire logic        host_irq,
    input wire logic        host_irq_deassert_timer_start,
    input wire logic        wake_event_out_o,
    input wire logic        wake_event_out_oe,
    input wire logic        irq
);
    // ------------------------------------------------------------------
    // shadow of the control word and asserted-pin run length
    // ------------------------------------------------------------------
    logic [15:0] ctl_q;
    logic [31:0] cnt_q;
    logic        act;
    // pin meaning follows the shadowed buffer type and polarity
    assign act = ctl_q[`WEC_PM_TYPE] ?
        (wake_event_out_oe && wake_event_out_o == ctl_q[`WEC_PM_POL]) : wake_event_out_oe;
    // shadow tracks writes only; no read-back, so W1C bits may be stale (unused)
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_q <= 16'h0000;
            cnt_q <= 32'h0000_0000;
        end else begin
            if (psel && penable && pwrite && paddr == `WEC_OFF_PMCTRL)
                ctl_q <= pwdata[15:0];
            cnt_q <= act ? cnt_q + 32'h0000_0001 : 32'h0000_0000;
        end
    end
    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_pp_held;
        ctl_q[`WEC_PM_TYPE] [*3];
    endsequence
    sequence s_gate_off;
        (!ctl_q[`WEC_PM_OUT_EN] && !ctl_q[`WEC_PM_PULSE]) [*3];
    endsequence
    chk_od_no_high: assert property (wake_event_out_o |-> wake_event_out_oe)
        else $error("wake pin driven high while released");
    chk_pp_drives: assert property (s_pp_held |-> wake_event_out_oe)
        else $error("push-pull wake pin not driven");
    chk_gate_off: assert property (s_gate_off |-> !act)
        else $error("wake pin asserted with output disabled");
    chk_pulse_len: assert property (ctl_q[`WEC_PM_PULSE] |-> cnt_q <= PULSE_CYCLES)
        else $error("wake pulse too long");
    chk_pd1_by_sw: assert property ($rose(port1_powered_down) |-> $past(psel && penable && pwrite))
        else $error("port1 powered down without a write");
    chk_pd2_by_sw: assert property ($rose(port2_powered_down) |-> $past(psel && penable && pwrite))
        else $error("port2 powered down without a write");
    // lan status trails the mac flags by one register, so a clear may land two edges late
    chk_irq_sticky: assert property ($fell(irq) |-> ($past(psel && penable && pwrite) || $past(psel && penable && pwrite, 2)))
        else $error("irq fell without a write");
    chk_timer_single: assert property (host_irq_deassert_timer_start |=> !host_irq_deassert_timer_start)
        else $error("timer start longer than one cycle");
    chk_irq_agree: assert property (irq == host_irq)
        else $error("host irq differs from irq");
endmodule // wec_combiner_asserts

bind wec_wake_event_combiner wec_combiner_asserts #(.PULSE_CYCLES(PULSE_CYCLES)) u_wec_combiner_asserts (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .port1_powered_down,
    .port2_powered_down, .host_irq, .host_irq_deassert_timer_start, .wake_event_out_o,
    .wake_event_out_oe, .irq);

// File: verification/wec_power_ctl_model.sv
// system power controller model watching the wake pin
module wec_power_ctl_model (
    input  wire logic pclk,
    input  wire logic wake_o,
    input  wire logic wake_oe,
    input  wire logic active_high,
    output logic      wake_seen,
    output int        last_width
);
    timeunit 1ns;
    timeprecision 1ns;
    logic level;
    int   run;
    // board pull-up holds the line high whenever the pin is released
    assign level = wake_oe ? wake_o : 1'b1;
    assign wake_seen = (level == active_high);
    // width of each assertion in clocks; no reset, controller sits on standby power
    always @(posedge pclk) begin
        if (wake_seen === 1'b1) begin
            run <= run + 1;
        end else begin
            if (run != 0) last_width <= run;
            run <= 0;
        end
    end
endmodule // wec_power_ctl_model

// File: verification/wec_wake_event_combiner_tb.sv
// testbench for the wake event combiner: bus tasks, scenarios and verdict
`include "wec_map.vh"
module wec_wake_event_combiner_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int PULSE = 20;
    logic        pclk, presetn, psel, penable, pwrite, err, wuf, mpk, act_hi;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, host_irq, tstart, wo, woe, irq, seen;
    logic [1:0]  pd, ev;
    int          width, base, cyc, n_tstart, n_mismatch, num_checks;

    wec_wake_event_combiner #(.PULSE_CYCLES(PULSE)) u_wec_wake_event_combiner (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .port1_energy_on_event(ev[0]), .port2_energy_on_event(ev[1]),
        .port1_other_phy_event(1'b0), .port2_other_phy_event(1'b0),
        .wakeup_frame_detect(wuf), .magic_packet_detect(mpk), .port1_powered_down(pd[0]),
        .port2_powered_down(pd[1]), .host_irq, .host_irq_deassert_timer_start(tstart),
        .wake_event_out_o(wo), .wake_event_out_oe(woe), .irq);
    wec_power_ctl_model u_wec_power_ctl_model (
        .pclk, .wake_o(wo), .wake_oe(woe), .active_high(act_hi), .wake_seen(seen),
        .last_width(width));

    // free-running bus clock
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // hang guard, also counts timer start pulses
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (tstart === 1'b1) n_tstart <= n_tstart + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            conclude();
        end
    end

    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one transfer; three idle edges after, since the wake pin trails a write by two
    // registers and a check made at the edge that launches it would see the old value
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask

    // reset values and a refused access to an unmapped word
    task automatic t_reset;
        apb(0, `WEC_OFF_PMCTRL, 0);
        chk("control reset", rd, `WEC_PM_RST);
        apb(0, `WEC_OFF_ISTAT, 0);
        chk("status reset", rd, `WEC_IS_RST);
        apb(1, 12'h0F0, 32'hFFFF_FFFF);
        chk("unmapped error", err, 1);
        apb(0, 12'h0F0, 0);
        chk("unmapped read", rd, 0);
    endtask
    // lan wake from both mac detectors, all three level pin modes, then clear
    task automatic t_lan;
        logic [31:0] md [3] = '{32'h0000_0060, 32'h0000_02E0, 32'h0000_00E0};
        apb(1, `WEC_OFF_HMWAKE, 32'h0000_0003);
        apb(1, `WEC_OFF_IMASK, 32'h0002_0000);
        for (int s = 0; s < 2; s++) begin
            wuf <= (s == 0);
            mpk <= (s == 1);
            repeat (6) @(posedge pclk);
            {wuf, mpk} <= 2'h0;
            apb(0, `WEC_OFF_HMWAKE, 0);
            chk("mac flag", rd[2+s], 1);
            apb(0, `WEC_OFF_PMCTRL, 0);
            chk("lan seen", rd[2], 1);
            chk("irq masked", irq, 0);
            apb(1, `WEC_OFF_PMCTRL, 32'h0000_0020);
            apb(0, `WEC_OFF_ISTAT, 0);
            chk("power event", rd[17], 1);
            chk("irq on", irq, 1);
            for (int m = 0; m < 3; m++) begin
                act_hi <= (m == 1);
                apb(1, `WEC_OFF_PMCTRL, md[m]);
                chk("wake on", seen, 1);
            end
            apb(1, `WEC_OFF_PMCTRL, 32'h0000_0020);
            chk("wake gated", seen, 0);
            base = n_tstart;
            apb(1, `WEC_OFF_HMWAKE, 32'h0000_000F);
            apb(1, `WEC_OFF_PMCTRL, 32'h0000_0004);
            chk("irq clear", irq, 0);
            chk("no timer start", n_tstart - base, 0);
        end
    endtask
    // energy wake per port: edpd exit, latch, port irq, single pulse, general power-down
    task automatic t_energy;
        apb(1, `WEC_OFF_PHYMASK, 32'h0000_0003);
        apb(1, `WEC_OFF_IMASK, 32'h0C00_0000);
        act_hi <= 1'b0;
        for (int p = 0; p < 2; p++) begin
            apb(1, `WEC_OFF_PMCTRL, (32'h0000_1008 << p) | 32'h0000_0140);
            chk("edpd entered", pd[p], 1);
            ev[p] <= 1'b1;
            repeat (6) @(posedge pclk);
            ev[p] <= 1'b0;
            chk("edpd exit", pd[p], 0);
            apb(0, `WEC_OFF_PMCTRL, 0);
            chk("energy seen", rd[p], 1);
            apb(0, `WEC_OFF_ISTAT, 0);
            chk("port irq", rd[26+p], 1);
            repeat (PULSE) @(posedge pclk);
            chk("pulse width", width, PULSE);
            chk("pulse once", seen, 0);
            base = n_tstart;
            apb(1, `WEC_OFF_ISTAT, 32'h0400_0000 << p);
            @(posedge pclk);
            chk("timer start", n_tstart - base, 1);
            apb(1, `WEC_OFF_PMCTRL, 32'h0000_0400 << p);
            chk("gpd entered", pd[p], 1);
            ev[p] <= 1'b1;
            repeat (6) @(posedge pclk);
            ev[p] <= 1'b0;
            chk("gpd held", pd[p], 1);
            apb(1, `WEC_OFF_PMCTRL, 32'h0000_0003);
            chk("gpd left", pd[p], 0);
            apb(1, `WEC_OFF_ISTAT, 32'h0C00_0000);
            chk("irq clear", irq, 0);
        end
    endtask

    // reset, scenarios, verdict
    initial begin
        {psel, penable, pwrite, wuf, mpk, act_hi, ev} = 8'h00;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        presetn = 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_lan();
        t_energy();
        conclude();
    end
endmodule // wec_wake_event_combiner_tb
